// ---- shared/lssi_cfg.svh ----
/*
  lssi_cfg.svh - constants of the led sink shift interface:
  channel count, serial output tap, reset values of the state.
  Assumes it is included by bare name from the package and the design.
*/
`ifndef LSSI_CFG_SVH
`define LSSI_CFG_SVH

// ==================================================================
// sizes
`define LSSI_CHANNELS 16
`define LSSI_SO_TAP 8

// ==================================================================
// reset values
`define LSSI_DATA_RST 16'h0000
`define LSSI_SO_RST 1'h1
`define LSSI_GATE_N_RST 1'h1

`endif

// ---- shared/lssi_pkg.sv ----
/*
  lssi_pkg - types of the led sink shift interface: diagnostic mode
  enumeration and the packed state record of the top module.
  Assumes lssi_cfg.svh is on the include path.
*/
`include "lssi_cfg.svh"

package lssi_pkg;

  // ================================================================
  // modes: gray codes along the stepping path, except the LOWCUR to NORMAL exit
  typedef enum logic [2:0] {
    LSSI_NORMAL = 3'h0,
    LSSI_GLOBAL = 3'h1,
    LSSI_OPEN = 3'h3,
    LSSI_SHORT = 3'h2,
    LSSI_TEMP = 3'h6,
    LSSI_LOWCUR = 3'h7
  } lssi_mode_e;

  typedef logic [`LSSI_CHANNELS-1:0] lssi_chan_t;

  // ================================================================
  // whole state of the top module
  typedef struct packed {
    lssi_chan_t shreg;
    lssi_chan_t data;
    lssi_chan_t sinks;
    lssi_chan_t open_rep;
    lssi_chan_t short_rep;
    logic temp_rep;
    logic gfault;
    logic sclk_d;
    logic load_d;
    lssi_mode_e mode;
    logic so;
    logic low_cur;
    logic sense_en;
  } lssi_state_s;

endpackage

// ---- hw/lssi_sync.sv ----
/*
  lssi_sync - two flip-flop synchroniser for a bundle of pin levels.
  Assumes each bit is an independent level; no word coherence is kept.
*/
`timescale 1ns/1ps

module lssi_sync
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } lssi_sync_s;

  lssi_sync_s s_ff;
  lssi_sync_s nxt_s;

  // ================================================================
  // first stage feeds only the second stage
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.meta = d;
    nxt_s.stab = s_ff.meta;
  end

  // ================================================================
  // register with clock enable
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_ff <= '0;
    end
    else if (ce)
    begin
      s_ff <= nxt_s;
    end
  end

  assign q = s_ff.stab;

endmodule

// ---- hw/lssi_top.sv ----
/*
  lssi_top - serial front end of a 16 channel led sink driver:
  shift register, display data register, output gating, serial
  output tap, diagnostic mode stepping and fault capture.
  Assumes a system clock much faster than the serial clock (at least
  four system cycles per serial half period); serial clock, data,
  load, gate and fault sense levels arrive asynchronously from pins
  and analog comparators.
*/
// Contract
// R1 - each serial clock rise shifts serial_in into the shift chain
// R2 - sixteen sink channels, each driven by one display data bit
// R3 - display data register separate; shifting leaves outputs unchanged
// R4 - in error mode each serial clock rise steps to next mode
// R5 - drive_gate_n low enables all sinks, high turns all off
// R6 - normal mode: serial_out shows each bit 8.5 clocks after capture
// R7 - global mode: serial_out low means fault found, high none
// R8 - detect heat, open, short; latch global and detailed results
// R9 - low current mode runs tests at reduced drive current
// R10 - diagnostic modes use channel pins as sense inputs
// R11 - load strobe rise copies shift register into display data; open, short and temp modes fill the shift chain with the report instead
// R12 - cascade: host chains serial_out to serial_in, fills all first
`timescale 1ns/1ps
`include "lssi_cfg.svh"

module lssi_top
#(
  parameter int CHANNELS = `LSSI_CHANNELS,
  parameter int SO_TAP = `LSSI_SO_TAP
)
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_IN,
  input wire logic LOAD_STROBE,
  input wire logic DRIVE_GATE_N,
  input wire lssi_pkg::lssi_chan_t SENSE_OPEN,
  input wire lssi_pkg::lssi_chan_t SENSE_SHORT,
  input wire logic OVER_TEMP,
  output lssi_pkg::lssi_chan_t SINK_CHANNELS,
  output logic SERIAL_OUT,
  output logic LOW_CURRENT,
  output logic SENSE_ENABLE
);

  import lssi_pkg::*;

  localparam int NSYNC = 2 * CHANNELS + 5;

  lssi_state_s s_ff;
  lssi_state_s nxt_s;
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] pins_sync;
  logic sclk;
  logic sdin;
  logic load;
  logic gate_n;
  logic hot;
  lssi_chan_t open_s;
  lssi_chan_t short_s;
  logic sclk_rise;
  logic sclk_fall;
  logic load_rise;
  logic in_diag;
  lssi_chan_t open_now;
  lssi_chan_t short_now;

  // ================================================================
  // pin synchronisers
  // all pin levels cross together; each bit settles on its own
  assign pins_raw = {SERIAL_CLK, SERIAL_IN, LOAD_STROBE, DRIVE_GATE_N,
                     OVER_TEMP, SENSE_OPEN, SENSE_SHORT};

  lssi_sync
  #(
    .W(NSYNC)
  )
  u_sync
  (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .d(pins_raw),
    .q(pins_sync)
  );

  // unpack the stable copies
  assign sclk = pins_sync[NSYNC-1];
  assign sdin = pins_sync[NSYNC-2];
  assign load = pins_sync[NSYNC-3];
  assign gate_n = pins_sync[NSYNC-4];
  assign hot = pins_sync[NSYNC-5];
  assign open_s = pins_sync[2*CHANNELS-1:CHANNELS];
  assign short_s = pins_sync[CHANNELS-1:0];

  // ================================================================
  // edge detection on the synchronised serial clock and load
  assign sclk_rise = sclk & ~s_ff.sclk_d;
  assign sclk_fall = ~sclk & s_ff.sclk_d;
  assign load_rise = load & ~s_ff.load_d;
  assign in_diag = (s_ff.mode != LSSI_NORMAL);

  // ================================================================
  // per channel fault judgement
  // only a lit channel can show open or short, so dark ones are masked
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : g_chan
      assign open_now[gi] = s_ff.data[gi] & open_s[gi]; // R8
      assign short_now[gi] = s_ff.data[gi] & short_s[gi]; // R8
    end
  endgenerate

  // ================================================================
  // next state
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.sclk_d = sclk;
    nxt_s.load_d = load;

    // serial shift on each rise, in every mode
    if (sclk_rise)
    begin
      nxt_s.shreg = {s_ff.shreg[CHANNELS-2:0], sdin}; // R1
    end

    // mode stepping
    // entry: serial clock rises while load is held high
    if (sclk_rise)
    begin
      if (in_diag)
      begin
        case (s_ff.mode) // R4
          LSSI_GLOBAL:
          begin
            nxt_s.mode = LSSI_OPEN;
          end
          LSSI_OPEN:
          begin
            nxt_s.mode = LSSI_SHORT;
          end
          LSSI_SHORT:
          begin
            nxt_s.mode = LSSI_TEMP;
          end
          LSSI_TEMP:
          begin
            nxt_s.mode = LSSI_LOWCUR;
          end
          LSSI_LOWCUR:
          begin
            nxt_s.mode = LSSI_NORMAL;
          end
          default:
          begin
            nxt_s.mode = LSSI_NORMAL;
          end
        endcase
      end
      else if (load)
      begin
        nxt_s.mode = LSSI_GLOBAL;
      end
    end

    // load strobe: latch display data and fault results
    // taken from the shift register as it stood before any same-cycle shift
    if (load_rise)
    begin
      case (s_ff.mode)
        LSSI_NORMAL:
        begin
          nxt_s.data = s_ff.shreg; // R11 R3
        end
        LSSI_GLOBAL, LSSI_LOWCUR:
        begin
          nxt_s.data = s_ff.shreg; // R11
          nxt_s.gfault = (|open_now) | (|short_now) | hot; // R8
          nxt_s.open_rep = open_now;
          nxt_s.short_rep = short_now;
          nxt_s.temp_rep = hot;
        end
        LSSI_OPEN:
        begin
          // detailed report is parked in the shift chain for read-back
          nxt_s.open_rep = open_now; // R8
          nxt_s.shreg = open_now;
        end
        LSSI_SHORT:
        begin
          nxt_s.short_rep = short_now; // R8
          nxt_s.shreg = short_now;
        end
        LSSI_TEMP:
        begin
          nxt_s.temp_rep = hot; // R8
          nxt_s.shreg = {CHANNELS{hot}};
        end
        default:
        begin
          nxt_s.data = s_ff.data;
        end
      endcase
    end

    // serial output
    // normal tap changes on the falling edge, half a clock after the rise
    if (s_ff.mode == LSSI_GLOBAL)
    begin
      nxt_s.so = ~s_ff.gfault; // R7
    end
    else if (sclk_fall)
    begin
      nxt_s.so = s_ff.shreg[SO_TAP]; // R6
    end

    // sink drive: gate overrides every mode
    nxt_s.sinks = gate_n ? '0 : s_ff.data; // R5 R2

    // analog mode controls
    nxt_s.sense_en = in_diag; // R10
    nxt_s.low_cur = (s_ff.mode == LSSI_LOWCUR); // R9
  end

  // ================================================================
  // state register, frozen while the clock enable is low
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      s_ff.shreg <= `LSSI_DATA_RST;
      s_ff.data <= `LSSI_DATA_RST;
      s_ff.sinks <= `LSSI_DATA_RST;
      s_ff.open_rep <= `LSSI_DATA_RST;
      s_ff.short_rep <= `LSSI_DATA_RST;
      s_ff.temp_rep <= 1'h0;
      s_ff.gfault <= 1'h0;
      s_ff.sclk_d <= 1'h0;
      s_ff.load_d <= 1'h0;
      s_ff.mode <= LSSI_NORMAL;
      s_ff.so <= `LSSI_SO_RST;
      s_ff.low_cur <= 1'h0;
      s_ff.sense_en <= 1'h0;
    end
    else if (CE)
    begin
      s_ff <= nxt_s;
    end
  end

  // ================================================================
  // outputs straight from flip-flops
  assign SINK_CHANNELS = s_ff.sinks;
  assign SERIAL_OUT = s_ff.so;
  assign LOW_CURRENT = s_ff.low_cur;
  assign SENSE_ENABLE = s_ff.sense_en;

endmodule

// ---- tb/lssi_host.sv ----
/*
  lssi_host - host model on the serial pins of lssi_top.
  Assumes a 100 ns system clock; one bit takes 800 ns.
*/
`timescale 1ns/1ps
module lssi_host
(
  input wire logic clk,
  output logic sclk,
  output logic serial_in,
  output logic ld
);
  // clock idles low outside frames
  initial
  begin
    sclk = 0;
    serial_in = 0;
    ld = 0;
  end

  // ==========================================
  // half period: 4 system cycles
  task automatic half();
    repeat (4) @(posedge clk);
    #5;
  endtask

  // data set a half period before the rise and held after it
  task automatic bits(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in = v[i];
      half();
      sclk = 1;
      half();
      sclk = 0;
    end
    serial_in = ~serial_in; // no stale level left on the line
    half();
  endtask

  // a rise while the strobe is high enters the error modes
  task automatic load(input bit step);
    ld = 1;
    half();
    if (step)
    begin
      sclk = 1;
      half();
      sclk = 0;
    end
    half();
    half();
    ld = 0;
    half();
    half();
  endtask
endmodule

// ---- tb/lssi_top_sva.sv ----
/*
  lssi_top_sva - port assertions of lssi_top.
  Assumes CE high and serial half periods of 4 system cycles.
*/
`timescale 1ns/1ps
module lssi_top_sva
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic SERIAL_CLK,
  input wire logic LOAD_STROBE,
  input wire logic DRIVE_GATE_N,
  input wire lssi_pkg::lssi_chan_t SINK_CHANNELS,
  input wire logic SERIAL_OUT,
  input wire logic LOW_CURRENT,
  input wire logic SENSE_ENABLE
);
  import lssi_pkg::*;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // ==========================================
  // pins quiet long enough to pass the synchroniser
  sequence gate_hi; DRIVE_GATE_N [*4]; endsequence
  sequence quiet; (!LOAD_STROBE && !DRIVE_GATE_N) [*8]; endsequence
  sequence clk_hi; (SERIAL_CLK && !SENSE_ENABLE) [*4]; endsequence

  gate_off_a: assert property (gate_hi |=> SINK_CHANNELS == '0) else $error("sinks on while gated");
  data_hold_a: assert property (quiet |=> $stable(SINK_CHANNELS)) else $error("sinks moved w/o load");
  so_hold_a: assert property (clk_hi ##1 !SENSE_ENABLE |-> $stable(SERIAL_OUT)) else $error("serial out moved");
  low_sense_a: assert property (LOW_CURRENT |-> SENSE_ENABLE) else $error("low current w/o sense");
  mode_entry_a: assert property ($rose(SENSE_ENABLE) |-> LOAD_STROBE && !LOW_CURRENT)
    else $error("bad entry to error mode");
  mode_exit_a: assert property ($fell(SENSE_ENABLE) |-> $fell(LOW_CURRENT)) else $error("bad exit");
  low_entry_a: assert property ($rose(LOW_CURRENT) |-> $past(SENSE_ENABLE)) else $error("bad step");
  low_step_a: assert property ($rose(LOW_CURRENT) |=> LOW_CURRENT [*4]) else $error("low current short");
endmodule

bind lssi_top lssi_top_sva i_lssi_top_sva (.CLK_SYS(CLK_SYS), .RST(RST), .SERIAL_CLK(SERIAL_CLK),
  .LOAD_STROBE(LOAD_STROBE), .DRIVE_GATE_N(DRIVE_GATE_N), .SINK_CHANNELS(SINK_CHANNELS),
  .SERIAL_OUT(SERIAL_OUT), .LOW_CURRENT(LOW_CURRENT), .SENSE_ENABLE(SENSE_ENABLE));

// ---- tb/lssi_top_tb.sv ----
/*
  lssi_top_tb - self-checking bench of lssi_top against a bit model.
  Assumes lssi_host on the serial pins and CE held high.
*/
`timescale 1ns/1ps
module lssi_top_tb;
  import lssi_pkg::*;
  logic clk_sys = 0;
  logic rst = 1;
  logic gate_n = 0;
  logic temp = 0;
  lssi_chan_t s_open = '0;
  lssi_chan_t s_short = '0;
  lssi_chan_t sinks;
  logic sclk, serial_in, ld, so, low_cur, sense;
  int n_errors = 0;
  int checked = 0;
  int seed = 32'ha70313f5;
  logic [15:0] v;
  logic [15:0] m_sh = '0;
  logic [15:0] m_data = '0;

  lssi_top i_lssi_top (.CLK_SYS(clk_sys), .RST(rst), .CE(1'b1), .SERIAL_CLK(sclk), .SERIAL_IN(serial_in),
    .LOAD_STROBE(ld), .DRIVE_GATE_N(gate_n), .SENSE_OPEN(s_open), .SENSE_SHORT(s_short),
    .OVER_TEMP(temp), .SINK_CHANNELS(sinks), .SERIAL_OUT(so), .LOW_CURRENT(low_cur), .SENSE_ENABLE(sense));
  lssi_host i_lssi_host (.clk(clk_sys), .sclk(sclk), .serial_in(serial_in), .ld(ld));

  // ==========================================
  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask

  // model: first bit sent ends at channel 15
  task automatic send(input logic [15:0] b, input int n);
    i_lssi_host.bits(b, n);
    for (int i = n - 1; i >= 0; i--)
      m_sh = {m_sh[14:0], b[i]};
  endtask

  // run takes about 860 cycles; limit leaves ample margin
  initial
  begin
    #400000;
    n_errors++;
    wrap_up();
  end

  initial
  begin
    wait_n(4);
    rst = 0;
    wait_n(2);
    chk("reset", {sinks, so, low_cur, sense}, 20'h00004);
    $display("reset done");
    for (int f = 0; f < 3; f++)
    begin
      v = $random(seed);
      send(v, 16);
      chk("sinks held", sinks, m_data);
      i_lssi_host.load(0);
      m_data = m_sh;
      chk("sinks load", sinks, m_data);
    end
    $display("frames done");
    for (int i = 0; i < 20; i++)
    begin
      v = $random(seed);
      send(v, 1);
      chk("serial out", so, m_sh[8]);
    end
    $display("tap done");
    gate_n = 1;
    wait_n(5);
    chk("gated", sinks, 16'h0000);
    gate_n = 0;
    wait_n(5);
    chk("ungated", sinks, m_data);
    $display("gate done");
    i_lssi_host.load(1);
    m_data = m_sh;
    m_sh = {m_sh[14:0], serial_in};
    chk("global", {low_cur, sense}, 2'b01);
    m_data = m_sh;
    i_lssi_host.load(0);
    chk("no fault", so, 1'b1);
    chk("global sinks", sinks, m_data);
    {s_open, s_short} = $random(seed);
    temp = s_open[0];
    wait_n(4);
    i_lssi_host.load(0);
    chk("fault", so, !(|(m_data & (s_open | s_short)) || temp));
    for (int i = 0; i < 5; i++)
    begin
      send(16'h0000, 1);
      chk("step", {low_cur, sense}, {i == 3, i < 4});
      // open mode load parks lit-and-open channels in the chain; later steps shift it out
      if (i == 0)
      begin
        i_lssi_host.load(0);
        m_sh = m_data & s_open;
      end
      else
        chk("open report", so, m_sh[8]);
    end
    $display("modes done");
    wrap_up();
  end
endmodule
